// ### pkg/aab_consts.svh
// Constants for the asynchronous-acknowledge bus transfer sequencer.
// Assumes inclusion by bare name from any file that needs them.
`ifndef AAB_CONSTS_SVH
`define AAB_CONSTS_SVH

`define AAB_ADDR_W 28
`define AAB_DATA_W 32
`define AAB_BEAT_W 4
`define AAB_MAX_BEATS 16
`define AAB_SYNC_INIT_N 1'h1

// Transfer size encodings on the bus
`define AAB_SIZE_LONG 2'h0
`define AAB_SIZE_BYTE 2'h1
`define AAB_SIZE_WORD 2'h2
`define AAB_SIZE_LINE 2'h3

// Data lanes used per port width
`define AAB_LANE_8 32'hFF00_0000
`define AAB_LANE_16 32'hFFFF_0000
`define AAB_LANE_32 32'hFFFF_FFFF

// Address step per beat, in bytes
`define AAB_STEP_8 4'h1
`define AAB_STEP_16 4'h2
`define AAB_STEP_32 4'h4

`endif

// ### pkg/aab_pkg.sv
// Types shared by the bus transfer sequencer files.
// Assumes aab_consts.svh holds the numeric constants.
package aab_pkg;

    // Gray-coded along idle -> start -> data
    typedef enum logic [1:0] {
        AAB_IDLE = 2'h0,
        AAB_START = 2'h1,
        AAB_DATA = 2'h3
    } aab_state_t;

    typedef logic [1:0] aab_size_t;

endpackage

// ### rtl/aab_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes a pin input asynchronous to mclk; output changes only once
// stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module aab_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronised reset, active low
    input wire logic [WIDTH-1:0] pin_in, // Raw pin level
    output logic [WIDTH-1:0] level_out // Filtered level
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    wire agree = (s2_reg == s3_reg);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level_out <= INIT;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_out <= s3_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/aab_beat_mem.sv
// Per-beat write image store, one bus image per beat, registered read.
// Assumes the user loads images before issuing the write request.
`timescale 1ns/1ns
`default_nettype none
module aab_beat_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronised reset, active low
    input wire logic wr_en_in, // Write strobe
    input wire logic [AW-1:0] wr_idx_in, // Write index
    input wire logic [WIDTH-1:0] wr_data_in, // Write image
    input wire logic [AW-1:0] rd_idx_in, // Read index
    output logic [WIDTH-1:0] rd_data_out // Registered read image
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_idx_in];
        end
    end
endmodule
`default_nettype wire

// ### rtl/aab_master.sv
// Bus-master cycle sequencer for single and burst transfers that end
// with a synchronous or asynchronous transfer acknowledge.
// Assumes one 20 MHz clock; all bus pins except outputs are asynchronous.
//
// Summary of operation
// R1: Read start: address, attributes, direction high, one-clock start strobe.
// R2: Write start: direction low, address, type, size, start strobe.
// R3: Size code 0 longword, 1 byte, 3 line.
// R4: Two-bit transfer type presented in the first clock.
// R5: Mode shows code/data first, then supervisor/user; start strobe negated.
// R6: Write data on all 32 lanes from clock two until acknowledged.
// R7: Byte read from 8-bit port captures top lane on internal acknowledge.
// R8: Negated internal acknowledge inserts wait states; completion needs it.
// R9: Acknowledge is synchronised internally before terminating a beat.
// R10: Slave holds acknowledge negated until ready, meeting setup.
// R11: Slave may capture write data at acknowledge or one clock later.
// R12: Slave acknowledging in clock two captures data by clock three end.
// R13: Burst-enable and operand wider than port gives a burst.
// R14: Bursts end on synchronous or asynchronous acknowledge, same attributes.
// R15: A burst has two to sixteen data beats.
// R16: Longword from 16-bit port: upper half lanes, step low address bits.
// R17: Line write to 32-bit port: step address bits 3:2, next longword.
// R18: A waiting burst-write beat keeps resampling internal acknowledge.
// R19: Data bus released the clock after the last write beat ends.
// R20: External asynchronous acknowledge passes a synchroniser before use.
// R21: Error acknowledge during synchronisation ends the transfer with error.
// R22: Asynchronous acknowledge honoured on all transfers except DRAM.
// R23: Address and attributes stay stable through all wait states.
`timescale 1ns/1ns
`default_nettype none
`include "aab_consts.svh"
module aab_master
    import aab_pkg::*;
#(
    parameter int ADDR_W = `AAB_ADDR_W,
    parameter int DATA_W = `AAB_DATA_W,
    parameter int BEAT_W = `AAB_BEAT_W
) (
    input wire logic mclk_in, // System clock, 20 MHz
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic req_in, // Start a transfer (pulse, idle only)
    input wire logic req_write_in, // 1 write, 0 read
    input wire logic [ADDR_W-1:0] req_addr_in, // Start address
    input wire logic [1:0] req_type_in, // Transfer type to present
    input wire logic req_code_in, // 1 code, 0 data
    input wire logic req_super_in, // 1 supervisor, 0 user
    input wire logic [1:0] req_opsize_in, // Operand size, bus encoding
    input wire logic [1:0] port_size_in, // Port width, size encoding
    input wire logic burst_en_in, // Burst-enable bit of select control
    input wire logic req_dram_in, // Target is DRAM
    input wire logic wr_en_in, // Load one write beat image
    input wire logic [BEAT_W-1:0] wr_idx_in, // Beat index of image
    input wire logic [DATA_W-1:0] wr_data_in, // Bus image of that beat
    input wire logic [DATA_W-1:0] data_in, // Data bus pins, input side
    input wire logic async_xfer_ack_n_in, // Asynchronous acknowledge pin
    input wire logic sync_xfer_ack_n_in, // Synchronous acknowledge pin
    input wire logic xfer_error_ack_n_in, // Error acknowledge pin
    output logic [ADDR_W-1:0] addr_out, // Address bus
    output logic [1:0] transfer_type_out, // Transfer type
    output aab_size_t transfer_size_out, // Transfer size
    output logic read_not_write_out, // Direction, high for read
    output logic access_mode_attr_out, // Code/data then super/user
    output logic transfer_start_n_out, // Transfer start strobe
    output logic [DATA_W-1:0] data_out, // Data bus pins, output side
    output logic data_oe_out, // Data bus driven while high
    output logic busy_out, // Transfer in progress
    output logic done_out, // Transfer finished (pulse)
    output logic error_out, // Finished with error (pulse)
    output logic [DATA_W-1:0] beat_data_out, // Captured read lanes
    output logic beat_valid_out // Read beat captured (pulse)
);

    // Reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_n_reg;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // Helpers
    function automatic logic [2:0] size_log2(input logic [1:0] s);
        case (s)
            `AAB_SIZE_BYTE: size_log2 = 3'd0;
            `AAB_SIZE_WORD: size_log2 = 3'd1;
            `AAB_SIZE_LONG: size_log2 = 3'd2;
            default: size_log2 = 3'd4;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] p);
        case (p)
            `AAB_SIZE_BYTE: lane_mask = `AAB_LANE_8;
            `AAB_SIZE_WORD: lane_mask = `AAB_LANE_16;
            default: lane_mask = `AAB_LANE_32;
        endcase
    endfunction

    function automatic logic [3:0] addr_step(input logic [1:0] p);
        case (p)
            `AAB_SIZE_BYTE: addr_step = `AAB_STEP_8;
            `AAB_SIZE_WORD: addr_step = `AAB_STEP_16;
            default: addr_step = `AAB_STEP_32;
        endcase
    endfunction

    // Pin synchronisers; the data bus goes through the same delay so
    // a captured word lines up with the acknowledge that qualifies it.
    logic async_ack_sync_n;
    logic sync_ack_sync_n;
    logic error_ack_sync_n;
    logic [DATA_W-1:0] data_sync;

    aab_sync #(.WIDTH(1), .INIT(`AAB_SYNC_INIT_N)) u_async_ack ( // [R20] [R9]
        .clk_in(mclk_in),
        .rst_n_in(rst_sync_n_reg),
        .pin_in(async_xfer_ack_n_in),
        .level_out(async_ack_sync_n)
    );
    aab_sync #(.WIDTH(1), .INIT(`AAB_SYNC_INIT_N)) u_sync_ack (
        .clk_in(mclk_in),
        .rst_n_in(rst_sync_n_reg),
        .pin_in(sync_xfer_ack_n_in),
        .level_out(sync_ack_sync_n)
    );
    aab_sync #(.WIDTH(1), .INIT(`AAB_SYNC_INIT_N)) u_error_ack (
        .clk_in(mclk_in),
        .rst_n_in(rst_sync_n_reg),
        .pin_in(xfer_error_ack_n_in),
        .level_out(error_ack_sync_n)
    );
    aab_sync #(.WIDTH(DATA_W), .INIT('0)) u_data (
        .clk_in(mclk_in),
        .rst_n_in(rst_sync_n_reg),
        .pin_in(data_in),
        .level_out(data_sync)
    );

    // State
    aab_state_t state_reg;
    logic [BEAT_W-1:0] beat_reg;
    logic [BEAT_W-1:0] last_beat_reg;
    logic burst_reg;
    logic write_reg;
    logic code_reg;
    logic super_reg;
    logic dram_reg;
    logic [1:0] port_reg;
    logic gap_reg;

    // Request decode
    wire [2:0] op_log2 = size_log2(req_opsize_in);
    wire [2:0] port_log2 = (&port_size_in) ? 3'h2 : size_log2(port_size_in);
    wire wider = (op_log2 > port_log2);
    wire [2:0] beat_shift = wider ? (op_log2 - port_log2) : 3'd0;
    wire [4:0] beat_count = 5'd1 << beat_shift; // [R15]
    wire [BEAT_W-1:0] req_last_beat = BEAT_W'(beat_count - 5'd1);
    wire req_burst = wider && burst_en_in; // [R13]
    // Inhibited multi-beat transfers show the port size instead
    wire [1:0] req_bus_size = (wider && !burst_en_in) ?
                              port_size_in : req_opsize_in; // [R3]

    // Beat termination
    wire async_ack = !async_ack_sync_n && !dram_reg; // [R22]
    wire beat_ack = !sync_ack_sync_n || async_ack; // [R14]
    wire beat_err = !error_ack_sync_n; // [R21]
    wire in_data = (state_reg == AAB_DATA);
    wire beat_end = in_data && beat_ack && !beat_err && !gap_reg; // [R8]
    wire beat_fail = in_data && beat_err;
    wire last_beat = (beat_reg == last_beat_reg);
    wire more_beats = beat_end && !last_beat;
    wire [BEAT_W-1:0] beat_next = more_beats ? beat_reg + 1'b1 :
                                  (busy_out ? beat_reg : '0);
    wire [3:0] low_next = addr_out[3:0] + addr_step(port_reg);

    // Write images: read index looks one edge ahead so the registered
    // image always matches the beat in progress.
    aab_beat_mem #(
        .WIDTH(DATA_W),
        .DEPTH(`AAB_MAX_BEATS),
        .AW(BEAT_W)
    ) u_beat_mem (
        .clk_in(mclk_in),
        .rst_n_in(rst_sync_n_reg),
        .wr_en_in(wr_en_in),
        .wr_idx_in(wr_idx_in),
        .wr_data_in(wr_data_in),
        .rd_idx_in(beat_next),
        .rd_data_out(data_out) // [R6] [R17]
    );

    // Sequencer
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            state_reg <= AAB_IDLE;
            beat_reg <= '0;
            gap_reg <= 1'b0;
        end else begin
            beat_reg <= beat_next;
            gap_reg <= more_beats;
            case (state_reg)
                AAB_IDLE: begin
                    if (req_in) begin
                        state_reg <= AAB_START;
                    end
                end
                AAB_START: begin
                    state_reg <= AAB_DATA;
                end
                AAB_DATA: begin
                    if (beat_fail || (beat_end && last_beat)) begin
                        state_reg <= AAB_IDLE;
                    end else if (more_beats && !burst_reg) begin
                        state_reg <= AAB_START;
                    end
                end
                default: begin
                    state_reg <= AAB_IDLE;
                end
            endcase
        end
    end

    // Request capture
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            last_beat_reg <= '0;
            burst_reg <= 1'b0;
            write_reg <= 1'b0;
            code_reg <= 1'b0;
            super_reg <= 1'b0;
            dram_reg <= 1'b0;
            port_reg <= `AAB_SIZE_LONG;
        end else if (state_reg == AAB_IDLE && req_in) begin
            last_beat_reg <= req_last_beat;
            burst_reg <= req_burst;
            write_reg <= req_write_in;
            code_reg <= req_code_in;
            super_reg <= req_super_in;
            dram_reg <= req_dram_in;
            port_reg <= port_size_in;
        end
    end

    // Address and attributes only move at a request or a beat end
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            addr_out <= '0;
            transfer_type_out <= 2'h0;
            transfer_size_out <= `AAB_SIZE_LONG;
            read_not_write_out <= 1'b1;
        end else if (state_reg == AAB_IDLE && req_in) begin
            addr_out <= req_addr_in; // [R1] [R2]
            transfer_type_out <= req_type_in; // [R4]
            transfer_size_out <= req_bus_size; // [R3]
            read_not_write_out <= !req_write_in; // [R1] [R2]
        end else if (more_beats) begin
            // Wraps inside the line [R16] [R17] [R23]
            addr_out <= {addr_out[ADDR_W-1:4], low_next};
        end
    end

    // Start strobe and access mode
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            transfer_start_n_out <= 1'b1;
            access_mode_attr_out <= 1'b0;
        end else if (state_reg == AAB_IDLE && req_in) begin
            transfer_start_n_out <= 1'b0; // [R1]
            access_mode_attr_out <= req_code_in; // [R5]
        end else if (state_reg == AAB_START) begin
            transfer_start_n_out <= 1'b1; // [R5]
            access_mode_attr_out <= super_reg; // [R5]
        end else if (more_beats && !burst_reg) begin
            transfer_start_n_out <= 1'b0;
            access_mode_attr_out <= code_reg;
        end
    end

    // Data drive: held through waits, dropped right after the last beat
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            data_oe_out <= 1'b0;
        end else if (state_reg == AAB_START) begin
            data_oe_out <= write_reg; // [R6]
        end else if (beat_fail || (beat_end && last_beat)) begin
            data_oe_out <= 1'b0; // [R19]
        end else if (more_beats && !burst_reg) begin
            data_oe_out <= 1'b0;
        end
    end

    // Read capture on the upper lanes of narrow ports
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            beat_data_out <= '0;
            beat_valid_out <= 1'b0;
        end else begin
            beat_valid_out <= beat_end && !write_reg;
            if (beat_end && !write_reg) begin
                beat_data_out <= data_sync & lane_mask(port_reg); // [R7] [R16]
            end
        end
    end

    // Completion status; error wins over a same-cycle acknowledge
    always_ff @(posedge mclk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            error_out <= 1'b0;
        end else begin
            done_out <= beat_fail || (beat_end && last_beat); // [R18]
            error_out <= beat_fail; // [R21]
            if (state_reg == AAB_IDLE && req_in) begin
                busy_out <= 1'b1;
            end else if (beat_fail || (beat_end && last_beat)) begin
                busy_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### verification/aab_master_checker.sv
// Port-level checks on the bus transfer sequencer, bound to aab_master.
// Assumes rst_n_in is held low from time zero.
`timescale 1ns/1ns
`default_nettype none
module aab_master_checker
    import aab_pkg::*;
(
    input wire logic mclk_in, // System clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic req_in, // Start request
    input wire logic req_write_in, // Write request
    input wire logic [1:0] req_type_in, // Requested type
    input wire logic req_code_in, // Code or data
    input wire logic req_super_in, // Supervisor or user
    input wire logic [1:0] req_opsize_in, // Operand size
    input wire logic [1:0] transfer_type_out, // Type on bus
    input wire aab_size_t transfer_size_out, // Size on bus
    input wire logic read_not_write_out, // Direction
    input wire logic access_mode_attr_out, // Mode attribute
    input wire logic transfer_start_n_out, // Start strobe
    input wire logic data_oe_out, // Data drive enable
    input wire logic busy_out, // Busy
    input wire logic done_out, // Done pulse
    input wire logic error_out // Error pulse
);
    logic take;
    assign take = req_in && !busy_out;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    start_pulse_a:
        assert property (take |=> !transfer_start_n_out && busy_out
            ##1 transfer_start_n_out)
        else $error("start strobe not a single clock");
    dir_level_a:
        assert property (take |=> read_not_write_out == !$past(req_write_in))
        else $error("direction wrong at start");
    type_shown_a:
        assert property (take |=> transfer_type_out == $past(req_type_in))
        else $error("transfer type wrong at start");
    byte_size_a:
        assert property (take && req_opsize_in == 2'h1
            |=> transfer_size_out == 2'h1)
        else $error("byte size code wrong");
    mode_phase_a:
        assert property (take |=> access_mode_attr_out == $past(req_code_in)
            ##1 access_mode_attr_out == $past(req_super_in, 2))
        else $error("mode attribute sequence wrong");
    wdata_drive_a:
        assert property (!transfer_start_n_out && !read_not_write_out
            |=> data_oe_out)
        else $error("write data not driven in second clock");
    attr_hold_a:
        assert property (busy_out && $past(busy_out) && transfer_start_n_out
            |-> $stable(transfer_type_out) && $stable(read_not_write_out))
        else $error("attributes moved during a beat");
    bus_release_a:
        assert property (done_out || read_not_write_out |-> !data_oe_out)
        else $error("data bus still driven");
    error_end_a:
        assert property (error_out |-> done_out)
        else $error("error without end of transfer");
endmodule
bind aab_master aab_master_checker i_chk (.mclk_in, .rst_n_in, .req_in,
    .req_write_in, .req_type_in, .req_code_in, .req_super_in,
    .req_opsize_in, .transfer_type_out, .transfer_size_out,
    .read_not_write_out, .access_mode_attr_out, .transfer_start_n_out,
    .data_oe_out, .busy_out, .done_out, .error_out);
`default_nettype wire

// ### verification/aab_slave_model.sv
// Behavioural selected slave: acknowledges each beat after a set delay.
// Assumes pulled-up acknowledge pins; data shows the last read word inverted when idle.
`timescale 1ns/1ns
`default_nettype none
module aab_slave_model (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic start_n_in, // Start strobe from master
    input wire logic busy_in, // Master busy
    input wire logic rnw_in, // Direction, high for read
    input wire logic [27:0] addr_in, // Address bus
    input wire logic [31:0] wdata_in, // Data bus level
    input wire logic [3:0] dly_in, // Clocks before acknowledging
    input wire logic use_sync_in, // Answer on synchronous pin
    input wire logic [31:0] salt_in, // Read pattern seed
    output logic async_ack_n_out, // Asynchronous acknowledge
    output logic sync_ack_n_out, // Synchronous acknowledge
    output logic [31:0] data_out, // Read data driven
    output logic cap_out, // Beat taken (pulse)
    output logic [27:0] cap_addr_out, // Address of beat taken
    output logic [31:0] cap_data_out // Data of beat taken
);
    logic [27:0] addr_reg;
    logic [4:0] cnt_reg;
    logic act_reg, new_beat, ack_on, drive;
    logic [31:0] last_reg, word;
    assign new_beat = !start_n_in || (busy_in && addr_in != addr_reg);
    // Two-clock pulse: shortest that survives the master's filter
    assign ack_on = act_reg && cnt_reg >= {1'h0, dly_in}
        && cnt_reg <= {1'h0, dly_in} + 5'h01;
    assign drive = act_reg && rnw_in && cnt_reg >= {1'h0, dly_in};
    assign word = salt_in ^ {8{addr_in[3:0]}};
    assign async_ack_n_out = !(ack_on && !use_sync_in);
    assign sync_ack_n_out = !(ack_on && use_sync_in);
    assign data_out = drive ? word : ~last_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_reg <= '0;
            cnt_reg <= '0;
            act_reg <= 1'h0;
            last_reg <= '0;
            cap_out <= 1'h0;
            cap_addr_out <= '0;
            cap_data_out <= '0;
        end else begin
            addr_reg <= addr_in;
            cap_out <= act_reg && cnt_reg == {1'h0, dly_in};
            cap_addr_out <= addr_in;
            cap_data_out <= rnw_in ? word : wdata_in;
            if (drive)
                last_reg <= word;
            if (new_beat)
                cnt_reg <= '0;
            else if (cnt_reg != 5'h1F)
                cnt_reg <= cnt_reg + 5'h01;
            act_reg <= new_beat || (act_reg && busy_in);
        end
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for aab_master with the slave model on its bus.
// Assumes one 20 MHz clock; expectations come from the request values.
`timescale 1ns/1ns
`default_nettype none
`include "aab_consts.svh"
module tb;
    import aab_pkg::*;
    logic mclk_in = 1'h0, rst_n_in = 1'h0, req_in = 1'h0;
    logic req_write_in = 1'h0, req_code_in = 1'h0, req_super_in = 1'h0;
    logic burst_en_in = 1'h0, req_dram_in = 1'h0, wr_en_in = 1'h0;
    logic xfer_error_ack_n_in = 1'h1, use_sync = 1'h0;
    logic [27:0] req_addr_in = '0, addr_out, cap_a;
    logic [1:0] req_type_in = '0, req_opsize_in = '0, port_size_in = '0;
    logic [3:0] wr_idx_in = '0, dly = '0;
    logic [31:0] wr_data_in = '0, salt = '0, data_out, slave_d, bus;
    logic [31:0] beat_data_out, cap_d;
    logic [1:0] transfer_type_out;
    aab_size_t transfer_size_out;
    logic read_not_write_out, access_mode_attr_out, transfer_start_n_out;
    logic data_oe_out, busy_out, done_out, error_out, beat_valid_out, cap;
    logic async_xfer_ack_n_in, sync_xfer_ack_n_in;
    logic [31:0] img [16];
    logic [59:0] exp_cap [$];
    logic [31:0] exp_rd [$];
    logic exp_end [$];
    int n_fail = 0, tests_run = 0, seed = 59330;
    assign bus = data_oe_out ? data_out : slave_d;
    aab_master i_dut (.mclk_in, .rst_n_in, .req_in, .req_write_in,
        .req_addr_in, .req_type_in, .req_code_in, .req_super_in,
        .req_opsize_in, .port_size_in, .burst_en_in, .req_dram_in,
        .wr_en_in, .wr_idx_in, .wr_data_in, .data_in(bus),
        .async_xfer_ack_n_in, .sync_xfer_ack_n_in, .xfer_error_ack_n_in,
        .addr_out, .transfer_type_out, .transfer_size_out,
        .read_not_write_out, .access_mode_attr_out, .transfer_start_n_out,
        .data_out, .data_oe_out, .busy_out, .done_out, .error_out,
        .beat_data_out, .beat_valid_out);
    aab_slave_model i_slave (.clk_in(mclk_in), .rst_n_in,
        .start_n_in(transfer_start_n_out), .busy_in(busy_out),
        .rnw_in(read_not_write_out), .addr_in(addr_out), .wdata_in(bus),
        .dly_in(dly), .use_sync_in(use_sync), .salt_in(salt),
        .async_ack_n_out(async_xfer_ack_n_in),
        .sync_ack_n_out(sync_xfer_ack_n_in), .data_out(slave_d),
        .cap_out(cap), .cap_addr_out(cap_a), .cap_data_out(cap_d));
    initial forever #25 mclk_in = ~mclk_in;
    task automatic check(string what, logic [63:0] exp, logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Oldest note first
    always @(posedge mclk_in) begin
        if (beat_valid_out === 1'h1)
            if (exp_rd.size() == 0) check("read extra", 0, 1);
            else check("read lanes", exp_rd.pop_front(), beat_data_out);
        if (cap === 1'h1)
            if (exp_cap.size() == 0) check("beat extra", 0, 1);
            else check("slave beat", exp_cap.pop_front(), {cap_a, cap_d});
        if (done_out === 1'h1)
            if (exp_end.size() == 0) check("done extra", 0, 1);
            else check("error flag", exp_end.pop_front(), error_out);
    end
    task automatic xfer(input logic w, input logic [1:0] os, ps,
                        input logic be, sy, dr, input logic [3:0] d);
        int pb, ob, nb, n;
        logic [27:0] a, ak;
        logic [31:0] m, wd, s;
        pb = (ps == 2'h1) ? 1 : (ps == 2'h2) ? 2 : 4;
        ob = (os == 2'h1) ? 1 : (os == 2'h2) ? 2 : (os == 2'h3) ? 16 : 4;
        nb = (ob > pb) ? ob / pb : 1;
        m = (pb == 1) ? `AAB_LANE_8 : (pb == 2) ? `AAB_LANE_16 : `AAB_LANE_32;
        a = 28'($random(seed));
        a[3:0] = a[3:0] & ~4'(ob - 1);
        s = $random(seed);
        for (int k = 0; k < nb; k++) begin
            @(posedge mclk_in);
            img[k] = $random(seed);
            wr_en_in <= 1'h1;
            wr_idx_in <= 4'(k);
            wr_data_in <= img[k];
        end
        @(posedge mclk_in);
        wr_en_in <= 1'h0;
        req_in <= 1'h1;
        req_write_in <= w;
        req_addr_in <= a;
        req_type_in <= 2'($random(seed));
        req_code_in <= 1'($random(seed));
        req_super_in <= 1'($random(seed));
        req_opsize_in <= os;
        port_size_in <= ps;
        burst_en_in <= be;
        req_dram_in <= dr;
        use_sync <= sy;
        dly <= d;
        salt <= s;
        for (int k = 0; k < (dr ? 1 : nb); k++) begin
            ak = {a[27:4], 4'(a[3:0] + k * pb)};
            wd = s ^ {8{ak[3:0]}};
            exp_cap.push_back({ak, w ? img[k] : wd});
            if (!w && !dr)
                exp_rd.push_back(wd & m);
        end
        exp_end.push_back(dr);
        @(posedge mclk_in);
        req_in <= 1'h0;
        if (dr) begin
            repeat (20) @(posedge mclk_in);
            xfer_error_ack_n_in <= 1'h0;
        end
        n = 0;
        do begin
            @(negedge mclk_in);
            n++;
        end while (done_out !== 1'h1 && n < 400);
        if (n >= 400) begin
            check("done wait", 0, 1);
            wrap_up();
        end
        if (dr) begin
            @(posedge mclk_in);
            xfer_error_ack_n_in <= 1'h1;
            // Error level lingers in the filter; let it drain
            repeat (8) @(posedge mclk_in);
        end
    endtask
    initial begin
        logic [31:0] r;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        repeat (3) @(posedge mclk_in);
        xfer(1'h0, 2'h1, 2'h1, 1'h1, 1'h0, 1'h0, 4'h0);
        xfer(1'h0, 2'h0, 2'h2, 1'h1, 1'h0, 1'h0, 4'h3);
        xfer(1'h1, 2'h3, 2'h0, 1'h1, 1'h0, 1'h0, 4'h1);
        xfer(1'h1, 2'h0, 2'h1, 1'h0, 1'h1, 1'h0, 4'h2);
        xfer(1'h0, 2'h3, 2'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        xfer(1'h0, 2'h0, 2'h0, 1'h1, 1'h0, 1'h1, 4'h0);
        repeat (8) begin
            r = $random(seed);
            xfer(r[0], r[2:1], r[4:3], r[5], r[6], 1'h0, r[10:7]);
        end
        repeat (4) @(posedge mclk_in);
        wrap_up();
    end
endmodule
`default_nettype wire
